// ===== logic/gpocfg_bank.sv
`timescale 1ns/1ps
`include "gpocfg_consts.svh"


module gpocfg_bank #(
    parameter int FIFO_CNT_W = 7
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_burst,
    input wire gpocfg_pkg::gpocfg_addr_t reg_addr,
    input wire gpocfg_pkg::gpocfg_byte_t reg_wdata,
    output gpocfg_pkg::gpocfg_byte_t reg_rdata,
    output logic reg_hit,
    input wire logic chip_ready_n,
    input wire logic crystal_osc_clock,
    input wire logic [63:0] int_signals,
    input wire logic wake_pulse,
    input wire logic [FIFO_CNT_W-1:0] rx_fifo_count,
    output logic rx_fill_reached,
    output logic [6:0] rx_fill_threshold_bytes,
    output gpocfg_pkg::gpocfg_atten_t close_in_atten,
    output logic out_pin_drive_strength,
    output gpocfg_pkg::gpocfg_byte_t internal_test_reg1,
    output gpocfg_pkg::gpocfg_byte_t internal_test_reg2,
    output logic out_pin2_o,
    output logic out_pin2_oe,
    output logic out_pin1_o,
    output logic out_pin1_oe,
    output logic out_pin0_o,
    output logic out_pin0_oe
);
    import gpocfg_pkg::*;

    // a narrower count could never reach the 64-byte threshold
    if (FIFO_CNT_W < 7) begin : g_cnt_too_narrow
        $error("fifo count must reach 64");
    end

    // ************************************************
    // register storage
    // ************************************************
    gpocfg_byte_t out_pin2_config_r;
    gpocfg_byte_t out_pin1_config_r;
    gpocfg_byte_t out_pin0_config_r;
    gpocfg_byte_t rx_fifo_threshold_config_r;
    gpocfg_addr_t burst_addr_r;
    logic burst_act_r;
    gpocfg_byte_t rdata_r;
    gpocfg_byte_t internal_test_reg1_r;
    gpocfg_byte_t internal_test_reg2_r;

    // masked merge keeps read-only bits at their reset value
    function automatic gpocfg_byte_t merge(input gpocfg_byte_t old_v, input gpocfg_byte_t new_v,
                                           input gpocfg_byte_t mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic addr_is(input gpocfg_addr_t a, input gpocfg_addr_t off);
        addr_is = (a == off);
    endfunction

    // ************************************************
    // address decode, burst auto-increment
    // ************************************************
    wire logic access_w;
    wire gpocfg_addr_t eff_addr_w;
    wire logic sel2_w;
    wire logic sel1_w;
    wire logic sel0_w;
    wire logic selt_w;
    wire gpocfg_addr_t burst_addr_nxt;

    // a burst byte with no burst running starts again from reg_addr
    assign access_w = reg_wr | reg_rd;
    assign eff_addr_w = (reg_burst && burst_act_r) ? burst_addr_r : reg_addr;
    assign burst_addr_nxt = eff_addr_w + 6'h01;
    assign sel2_w = addr_is(eff_addr_w, `GPOCFG_OFF_PIN2);
    assign sel1_w = addr_is(eff_addr_w, `GPOCFG_OFF_PIN1);
    assign sel0_w = addr_is(eff_addr_w, `GPOCFG_OFF_PIN0);
    assign selt_w = addr_is(eff_addr_w, `GPOCFG_OFF_RXTHR);
    assign reg_hit = access_w & (sel2_w | sel1_w | sel0_w | selt_w);

    // burst state survives across bytes until a single access ends it
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            burst_act_r <= 1'b0;
        end else if (access_w) begin
            burst_act_r <= reg_burst;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            burst_addr_r <= 6'h00;
        end else if (access_w) begin
            burst_addr_r <= burst_addr_nxt;
        end
    end

    // ************************************************
    // writes; no sleep input clears anything here
    // ************************************************
    wire logic wr2_w;
    wire logic wr1_w;
    wire logic wr0_w;
    wire logic wrt_w;
    wire gpocfg_byte_t out_pin2_config_nxt;
    wire gpocfg_byte_t out_pin1_config_nxt;
    wire gpocfg_byte_t out_pin0_config_nxt;
    wire gpocfg_byte_t rx_fifo_threshold_config_nxt;

    assign wr2_w = reg_wr & sel2_w;
    assign wr1_w = reg_wr & sel1_w;
    assign wr0_w = reg_wr & sel0_w;
    assign wrt_w = reg_wr & selt_w;
    assign out_pin2_config_nxt = merge(out_pin2_config_r, reg_wdata, `GPOCFG_MASK_PIN2);
    assign out_pin1_config_nxt = merge(out_pin1_config_r, reg_wdata, `GPOCFG_MASK_PIN1);
    assign out_pin0_config_nxt = merge(out_pin0_config_r, reg_wdata, `GPOCFG_MASK_PIN0);
    assign rx_fifo_threshold_config_nxt = merge(rx_fifo_threshold_config_r, reg_wdata,
                                                `GPOCFG_MASK_RXTHR);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_pin2_config_r <= `GPOCFG_RST_PIN2;
        end else if (wr2_w) begin
            out_pin2_config_r <= out_pin2_config_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_pin1_config_r <= `GPOCFG_RST_PIN1;
        end else if (wr1_w) begin
            out_pin1_config_r <= out_pin1_config_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_pin0_config_r <= `GPOCFG_RST_PIN0;
        end else if (wr0_w) begin
            out_pin0_config_r <= out_pin0_config_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_fifo_threshold_config_r <= `GPOCFG_RST_RXTHR;
        end else if (wrt_w) begin
            rx_fifo_threshold_config_r <= rx_fifo_threshold_config_nxt;
        end
    end

    // ************************************************
    // read data, one cycle after the strobe
    // ************************************************
    wire gpocfg_byte_t rd_mux_w;

    assign rd_mux_w = sel2_w ? out_pin2_config_r :
                      sel1_w ? out_pin1_config_r :
                      sel0_w ? out_pin0_config_r :
                      selt_w ? rx_fifo_threshold_config_r : 8'h00;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux_w;
        end
    end
    assign reg_rdata = rdata_r;

    // ************************************************
    // fifo threshold
    // ************************************************
    wire logic [3:0] thr_set_w;
    wire logic [6:0] thr_bytes_w;

    assign thr_set_w = rx_fifo_threshold_config_r[3:0];
    assign thr_bytes_w = {1'b0, thr_set_w, 2'b00} + 7'h04;
    assign rx_fill_threshold_bytes = thr_bytes_w;
    assign rx_fill_reached = (rx_fifo_count >= FIFO_CNT_W'(thr_bytes_w));

    assign close_in_atten = rx_fifo_threshold_config_r[`GPOCFG_ATT_HI:`GPOCFG_ATT_LO];
    assign out_pin_drive_strength = out_pin1_config_r[`GPOCFG_DS_BIT];

    // ************************************************
    // wake-up test values, analog side only
    // ************************************************
    wire logic keep_w;

    assign keep_w = rx_fifo_threshold_config_r[`GPOCFG_KEEP_BIT];

    wire gpocfg_byte_t internal_test_reg1_nxt;
    wire gpocfg_byte_t internal_test_reg2_nxt;

    assign internal_test_reg1_nxt = keep_w ? `GPOCFG_T1_KEEP : `GPOCFG_T1_NOKEEP;
    assign internal_test_reg2_nxt = keep_w ? `GPOCFG_T2_KEEP : `GPOCFG_T2_NOKEEP;

    // these never reach reg_rdata, so host reads are unaffected
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            internal_test_reg1_r <= `GPOCFG_T1_NOKEEP;
            internal_test_reg2_r <= `GPOCFG_T2_NOKEEP;
        end else if (wake_pulse) begin
            internal_test_reg1_r <= internal_test_reg1_nxt;
            internal_test_reg2_r <= internal_test_reg2_nxt;
        end
    end
    assign internal_test_reg1 = internal_test_reg1_r;
    assign internal_test_reg2 = internal_test_reg2_r;

    // ************************************************
    // crystal divider and pin muxing
    // ************************************************
    logic cr_s1_r;
    logic cr_s2_r;
    logic xo_s1_r;
    logic xo_s2_r;
    logic xo_d_r;
    logic [7:0] div_cnt_r;
    logic div_out_r;
    wire logic xo_rise_w;
    wire logic [63:0] sig_w;

    // pins come from other domains, two flops before use
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cr_s1_r <= 1'b1;
            cr_s2_r <= 1'b1;
            xo_s1_r <= 1'b0;
            xo_s2_r <= 1'b0;
            xo_d_r <= 1'b0;
        end else begin
            cr_s1_r <= chip_ready_n;
            cr_s2_r <= cr_s1_r;
            xo_s1_r <= crystal_osc_clock;
            xo_s2_r <= xo_s1_r;
            xo_d_r <= xo_s2_r;
        end
    end
    assign xo_rise_w = xo_s2_r & ~xo_d_r;

    // toggling every 96 rising edges yields a period of 192
    // the synchroniser adds up to one core clock of jitter to each edge
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_cnt_r <= 8'h00;
            div_out_r <= 1'b0;
        end else if (xo_rise_w) begin
            if (div_cnt_r == 8'((`GPOCFG_XOSC_DIV / 2) - 1)) begin
                div_cnt_r <= 8'h00;
                div_out_r <= ~div_out_r;
            end else begin
                div_cnt_r <= div_cnt_r + 8'h01;
            end
        end
    end

    // all other codes come from the rest of the chip; fixed codes are owned here
    assign sig_w = {div_out_r, int_signals[62:47], 1'b0, int_signals[45:42], cr_s2_r,
                    int_signals[40:0]};

    // all three drivers see the same source vector
    gpocfg_pin_drv u_pin2 (
        .sel(out_pin2_config_r[5:0]),
        .invert(out_pin2_config_r[`GPOCFG_INV_BIT]),
        .signals(sig_w),
        .pin_o(out_pin2_o),
        .pin_oe(out_pin2_oe)
    );

    gpocfg_pin_drv u_pin1 (
        .sel(out_pin1_config_r[5:0]),
        .invert(out_pin1_config_r[`GPOCFG_INV_BIT]),
        .signals(sig_w),
        .pin_o(out_pin1_o),
        .pin_oe(out_pin1_oe)
    );

    gpocfg_pin_drv u_pin0 (
        .sel(out_pin0_config_r[5:0]),
        .invert(out_pin0_config_r[`GPOCFG_INV_BIT]),
        .signals(sig_w),
        .pin_o(out_pin0_o),
        .pin_oe(out_pin0_oe)
    );
endmodule

// ===== inc/gpocfg_consts.svh
`ifndef GPOCFG_CONSTS_SVH
`define GPOCFG_CONSTS_SVH

// register offsets on the serial register port
`define GPOCFG_OFF_PIN2 6'h00
`define GPOCFG_OFF_PIN1 6'h01
`define GPOCFG_OFF_PIN0 6'h02
`define GPOCFG_OFF_RXTHR 6'h03

// field positions
`define GPOCFG_INV_BIT 6
`define GPOCFG_DS_BIT 7
`define GPOCFG_KEEP_BIT 6
`define GPOCFG_ATT_LO 4
`define GPOCFG_ATT_HI 5

// reset values
`define GPOCFG_RST_PIN2 8'h29
`define GPOCFG_RST_PIN1 8'h2e
`define GPOCFG_RST_PIN0 8'h3f
`define GPOCFG_RST_RXTHR 8'h07

// writable bit masks
`define GPOCFG_MASK_PIN2 8'h7f
`define GPOCFG_MASK_PIN1 8'hff
`define GPOCFG_MASK_PIN0 8'hff
`define GPOCFG_MASK_RXTHR 8'hff

// wake-up internal test values
`define GPOCFG_T1_NOKEEP 8'h31
`define GPOCFG_T2_NOKEEP 8'h88
`define GPOCFG_T1_KEEP 8'h35
`define GPOCFG_T2_KEEP 8'h81

// selection codes with fixed meaning
`define GPOCFG_SEL_CHIP_RDY_N 6'h29
`define GPOCFG_SEL_HIZ 6'h2e
`define GPOCFG_SEL_XOSC_DIV 6'h3f
`define GPOCFG_XOSC_DIV 192

`endif

// ===== inc/gpocfg_pkg.sv
package gpocfg_pkg;
    typedef logic [7:0] gpocfg_byte_t;
    typedef logic [5:0] gpocfg_addr_t;
    typedef logic [5:0] gpocfg_sel_t;
    typedef logic [1:0] gpocfg_atten_t;
endpackage

// ===== logic/gpocfg_pin_drv.sv
`timescale 1ns/1ps
`include "gpocfg_consts.svh"

module gpocfg_pin_drv (
    input wire logic [5:0] sel,
    input wire logic invert,
    input wire logic [63:0] signals,
    output logic pin_o,
    output logic pin_oe
);
    wire logic raw_w;
    wire logic hiz_w;

    assign raw_w = signals[sel];
    assign hiz_w = (sel == `GPOCFG_SEL_HIZ);
    assign pin_o = raw_w ^ invert;
    assign pin_oe = !hiz_w;
endmodule

// ===== test/gpocfg_checker.sv
`timescale 1ns/1ps
module gpocfg_checker
import gpocfg_pkg::*;
#(parameter int FIFO_CNT_W = 7) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_burst,
    input wire gpocfg_pkg::gpocfg_addr_t reg_addr,
    input wire gpocfg_pkg::gpocfg_byte_t reg_wdata,
    input wire gpocfg_pkg::gpocfg_byte_t reg_rdata,
    input wire logic reg_hit,
    input wire logic wake_pulse,
    input wire logic [FIFO_CNT_W-1:0] rx_fifo_count,
    input wire logic rx_fill_reached,
    input wire logic [6:0] rx_fill_threshold_bytes,
    input wire gpocfg_pkg::gpocfg_atten_t close_in_atten,
    input wire logic out_pin_drive_strength,
    input wire gpocfg_pkg::gpocfg_byte_t internal_test_reg1,
    input wire gpocfg_pkg::gpocfg_byte_t internal_test_reg2,
    input wire logic out_pin1_oe
);
default clocking @(posedge core_clk); endclocking
default disable iff (reset);
wire logic wr1 = reg_wr && !reg_burst && reg_addr == 6'h01;
wire logic wr3 = reg_wr && !reg_burst && reg_addr == 6'h03;
wire logic rd_s = reg_rd && !reg_burst;
// burst writes never reach offset 3 in the bench, so single writes suffice
logic keep_r;
always_ff @(posedge core_clk or posedge reset) begin
    if (reset) keep_r <= 1'b0;
    else if (wr3) keep_r <= reg_wdata[6];
end
a_fill_level: assert property (rx_fill_reached == (rx_fifo_count >= rx_fill_threshold_bytes))
    else $error("fill flag wrong");
a_thr_bytes: assert property (wr3 |=>
    rx_fill_threshold_bytes == {({1'b0, $past(reg_wdata[3:0])} + 5'd1), 2'b00})
    else $error("threshold bytes wrong");
a_atten_field: assert property (wr3 |=> close_in_atten == $past(reg_wdata[5:4]))
    else $error("attenuation wrong");
a_drive_field: assert property (wr1 |=> out_pin_drive_strength == $past(reg_wdata[7]))
    else $error("drive strength wrong");
a_hiz_code: assert property (wr1 |=> out_pin1_oe == ($past(reg_wdata[5:0]) != 6'h2e))
    else $error("pin1 enable wrong");
a_wake_values: assert property (wake_pulse |=>
    internal_test_reg1 == (keep_r ? 8'h35 : 8'h31) && internal_test_reg2 == (keep_r ? 8'h81 : 8'h88))
    else $error("wake values wrong");
a_unmapped_zero: assert property (rd_s && reg_addr > 6'h03 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
a_map_hit: assert property (rd_s |-> reg_hit == (reg_addr <= 6'h03))
    else $error("hit flag wrong");
a_pin2_msb: assert property (rd_s && reg_addr == 6'h00 |=> !reg_rdata[7])
    else $error("pin2 bit7 not zero");
a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
c_thr: cover property (wr3);
c_wake_keep: cover property (wake_pulse && keep_r);
c_burst_rd: cover property (reg_rd && reg_burst);
endmodule
bind gpocfg_bank gpocfg_checker #(.FIFO_CNT_W(FIFO_CNT_W)) u_chk (
    .core_clk(core_clk),
    .reset(reset),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_burst(reg_burst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .wake_pulse(wake_pulse),
    .rx_fifo_count(rx_fifo_count),
    .rx_fill_reached(rx_fill_reached),
    .rx_fill_threshold_bytes(rx_fill_threshold_bytes),
    .close_in_atten(close_in_atten),
    .out_pin_drive_strength(out_pin_drive_strength),
    .internal_test_reg1(internal_test_reg1),
    .internal_test_reg2(internal_test_reg2),
    .out_pin1_oe(out_pin1_oe)
);

// ===== test/gpocfg_host.sv
`timescale 1ns/1ps
module gpocfg_host
import gpocfg_pkg::*;
(
    input wire logic core_clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_burst,
    output gpocfg_pkg::gpocfg_addr_t reg_addr,
    output gpocfg_pkg::gpocfg_byte_t reg_wdata,
    input wire gpocfg_pkg::gpocfg_byte_t reg_rdata
);
initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_burst = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
end
// one byte per call; every burst byte carries reg_burst high, and a
// single access must stand between two bursts or they chain together
task automatic xfer(input logic w, input gpocfg_addr_t a, input gpocfg_byte_t d,
        input logic b, output gpocfg_byte_t q);
    @(negedge core_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    reg_burst <= b;
    @(negedge core_clk);
    q = reg_rdata;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_burst <= 1'b0;
    // released lines show the inverse so stale values cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
endtask
task automatic init(output gpocfg_byte_t q);
    xfer(1'b1, 6'h02, 8'h2e, 1'b0, q);
endtask
endmodule

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
import gpocfg_pkg::*;
logic core_clk = 0, reset = 1, reg_wr, reg_rd, reg_burst, reg_hit, chip_ready_n;
logic crystal_osc_clock = 0, wake_pulse, rx_fill_reached, out_pin_drive_strength;
logic out_pin2_o, out_pin2_oe, out_pin1_o, out_pin1_oe, out_pin0_o, out_pin0_oe;
gpocfg_addr_t reg_addr, a;
gpocfg_byte_t reg_wdata, reg_rdata, internal_test_reg1, internal_test_reg2, d, q;
gpocfg_byte_t mem [4] = '{8'h29, 8'h2e, 8'h3f, 8'h07};
gpocfg_atten_t close_in_atten;
logic [63:0] int_signals;
logic [6:0] rx_fifo_count, rx_fill_threshold_bytes;
integer seed = 32'hccd3f1ae;
int num_errors = 0, n_tests = 0;
int cnt;
logic lvl, ok;
always #20 core_clk = ~core_clk;
always #70 crystal_osc_clock = ~crystal_osc_clock;
gpocfg_bank #(.FIFO_CNT_W(7)) i_dut (.*);
gpocfg_host i_host (.*);
function automatic gpocfg_byte_t thr_exp(input int n);
    return 8'((n + 1) * 4);
endfunction
// core cycles per half period of the divided crystal clock (140 ns crystal period)
function automatic int half_exp();
    return 192 / 2 * 140 / 40;
endfunction
function automatic gpocfg_byte_t rd_exp(input gpocfg_addr_t x, input gpocfg_byte_t v);
    return x > 6'h03 ? 8'h00 : (x == 6'h00 ? v & 8'h7f : v);
endfunction
task chk(input string nm, input gpocfg_byte_t exp, input gpocfg_byte_t got);
    n_tests++;
    if (got !== exp) begin
        num_errors++;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
endtask
task complete_run;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
initial begin
    #(40 * 4000);
    num_errors++;
    complete_run;
end
//****************
// main sequence
//****************
initial begin
    {int_signals, chip_ready_n, wake_pulse, rx_fifo_count} = '0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
        i_host.xfer(1'b0, 6'(i), 8'h00, 1'b0, q);
        chk("reset value", mem[i], q);
    end
    chk("pin1 enable", 8'h00, {7'h0, out_pin1_oe});
    chk("threshold", 8'd32, {1'b0, rx_fill_threshold_bytes});
    i_host.init(q);
    mem[2] = 8'h2e;
    chk("pin0 enable", 8'h00, {7'h0, out_pin0_oe});
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
        a = 6'($random(seed)) & 6'h07;
        d = 8'($random(seed));
        i_host.xfer(1'b1, a, d, 1'b0, q);
        if (a < 6'h04) mem[a[1:0]] = rd_exp(a, d);
        i_host.xfer(1'b0, a, 8'h00, 1'b0, q);
        chk("readback", a < 6'h04 ? mem[a[1:0]] : 8'h00, q);
    end
    for (int j = 0; j < 3; j++) begin
        mem[j] = rd_exp(6'(j), 8'($random(seed)));
        i_host.xfer(1'b1, j == 0 ? 6'h00 : 6'h3f, mem[j], 1'b1, q);
    end
    // a single access closes the write burst before the read burst opens
    i_host.xfer(1'b0, 6'h04, 8'h00, 1'b0, q);
    chk("unmapped", 8'h00, q);
    for (int j = 0; j < 3; j++) begin
        i_host.xfer(1'b0, j == 0 ? 6'h00 : 6'h3f, 8'h00, 1'b1, q);
        chk("burst", mem[j], q);
    end
    $display("test access done");
    for (int v = 0; v < 2; v++) begin
        i_host.xfer(1'b1, 6'h00, {1'b0, v[0], 6'h05}, 1'b0, q);
        i_host.xfer(1'b1, 6'h01, {v[0], v[0], 6'h05}, 1'b0, q);
        i_host.xfer(1'b1, 6'h02, {1'b0, v[0], 6'h05}, 1'b0, q);
        chk("drive", {7'h0, v[0]}, {7'h0, out_pin_drive_strength});
        chk("pin enables", 8'h07, {5'h0, out_pin2_oe, out_pin1_oe, out_pin0_oe});
        repeat (4) begin
            int_signals = {$random(seed), $random(seed)};
            repeat (2) @(negedge core_clk);
            chk("pin2 level", {7'h0, int_signals[5] ^ v[0]}, {7'h0, out_pin2_o});
            d = {6'h0, {2{int_signals[5] ^ v[0]}}};
            chk("pin1 pin0 level", d, {6'h0, out_pin1_o, out_pin0_o});
        end
    end
    $display("test pins done");
    i_host.xfer(1'b1, 6'h00, 8'h29, 1'b0, q);
    for (int r = 0; r < 2; r++) begin
        @(negedge core_clk) chip_ready_n = ~r[0];
        repeat (3) @(negedge core_clk);
        chk("chip ready pin", {7'h0, ~r[0]}, {7'h0, out_pin2_o});
    end
    i_host.xfer(1'b1, 6'h02, 8'h3f, 1'b0, q);
    for (int e = 0; e < 2; e++) begin
        lvl = out_pin0_o;
        cnt = 0;
        while (out_pin0_o == lvl && cnt < 800) begin
            @(negedge core_clk);
            cnt++;
        end
    end
    ok = cnt >= half_exp() - 1 && cnt <= half_exp() + 1;
    chk("clock half period", 8'h01, {7'h0, ok});
    $display("test routing done");
    for (int n = 0; n < 16; n++) begin
        i_host.xfer(1'b1, 6'h03, {2'b00, 2'(n), 4'(n)}, 1'b0, q);
        chk("threshold", thr_exp(n), {1'b0, rx_fill_threshold_bytes});
        chk("atten", 8'(n % 4), {6'h0, close_in_atten});
        for (int c = -1; c < 1; c++) begin
            rx_fifo_count = 7'(thr_exp(n) + c);
            #1;
            chk("fill", 8'(c + 1), {7'h0, rx_fill_reached});
        end
    end
    $display("test threshold done");
    for (int k = 0; k < 2; k++) begin
        i_host.xfer(1'b1, 6'h03, {1'b0, k[0], 6'h3a}, 1'b0, q);
        @(negedge core_clk) wake_pulse = 1'b1;
        @(negedge core_clk) wake_pulse = 1'b0;
        chk("internal_test_reg1", k ? 8'h35 : 8'h31, internal_test_reg1);
        chk("internal_test_reg2", k ? 8'h81 : 8'h88, internal_test_reg2);
        i_host.xfer(1'b0, 6'h03, 8'h00, 1'b0, q);
        chk("kept", {1'b0, k[0], 6'h3a}, q);
        i_host.xfer(1'b0, 6'h2c, 8'h00, 1'b0, q);
        chk("test hidden", 8'h00, q);
    end
    $display("test wake done");
    complete_run;
end
endmodule
